//--- dtcc_pkg.sv
// Package of register map, field positions and reset values for the dual timer common control.
package dtcc_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] DTCC_RUN_ADDR = 8'h00;
	localparam logic [7:0] DTCC_MODE_ADDR = 8'h04;
	localparam logic [7:0] DTCC_PWM_ADDR = 8'h08;
	localparam logic [7:0] DTCC_COMB_ADDR = 8'h0C;
	localparam logic [7:0] DTCC_STAT_ADDR = 8'h10;
	// ----------------------------------------------------------------
	// Reset values and reserved masks (reserved bits read one)
	// ----------------------------------------------------------------
	localparam logic [7:0] DTCC_RUN_RSV = 8'hFC;
	localparam logic [7:0] DTCC_MODE_RSV = 8'h0E;
	localparam logic [7:0] DTCC_PWM_RSV = 8'h88;
	localparam logic [7:0] DTCC_RUN_RESET = 8'hFC;
	localparam logic [7:0] DTCC_MODE_RESET = 8'h0E;
	localparam logic [7:0] DTCC_PWM_RESET = 8'h88;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DTCC_RUN_CH0 = 0;
	localparam int DTCC_RUN_CH1 = 1;
	localparam int DTCC_LOCKSTEP = 0;
	localparam int DTCC_BUF_C_CH0 = 4;
	localparam int DTCC_BUF_D_CH0 = 5;
	localparam int DTCC_BUF_C_CH1 = 6;
	localparam int DTCC_BUF_D_CH1 = 7;
	localparam int DTCC_PWM_B_CH0 = 0;
	localparam int DTCC_PWM_C_CH0 = 1;
	localparam int DTCC_PWM_D_CH0 = 2;
	localparam int DTCC_PWM_B_CH1 = 4;
	localparam int DTCC_PWM_C_CH1 = 5;
	localparam int DTCC_PWM_D_CH1 = 6;
	// ----------------------------------------------------------------
	// Combined modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DTCC_COMB_NORMAL = 2'b00,
		DTCC_COMB_RESET_SYNC = 2'b01,
		DTCC_COMB_COMPL_TROUGH = 2'b10,
		DTCC_COMB_COMPL_CREST = 2'b11
	} dtcc_comb_e;
	// Pin role codes.
	typedef enum logic [1:0] {
		DTCC_ROLE_COMPARE = 2'b00,
		DTCC_ROLE_CAPTURE = 2'b01,
		DTCC_ROLE_PWM = 2'b10,
		DTCC_ROLE_CLOCK = 2'b11
	} dtcc_role_e;
endpackage

//--- dtcc_reg8.sv
// One 8-bit control register with reserved bits that read one and ignore writes.
module dtcc_reg8 #(
	parameter logic [7:0] RSV = 8'h00,
	parameter logic [7:0] RESET = 8'h00
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RESET;
		end else if (wr) begin
			q <= (wdata & ~RSV) | RSV;
		end
	end
endmodule

//--- dtcc_pin_role.sv
// Role selection for one capture/compare pin from its capture, pwm and combined-mode controls.
module dtcc_pin_role (
	input wire logic capture_sel,
	input wire logic pwm_sel,
	input wire logic comb_pwm,
	input wire logic clock_sel,
	output logic [1:0] role
);
	import dtcc_pkg::*;
	always_comb begin
		if (comb_pwm) begin
			role = DTCC_ROLE_PWM;
		end else if (pwm_sel) begin
			role = DTCC_ROLE_PWM;
		end else if (clock_sel) begin
			role = DTCC_ROLE_CLOCK;
		end else if (capture_sel) begin
			role = DTCC_ROLE_CAPTURE;
		end else begin
			role = DTCC_ROLE_COMPARE;
		end
	end
endmodule

//--- dtcc_common_ctrl.sv
// Common control of the dual 16-bit timer: run, buffer/lockstep and pin pwm registers.
// Contract
// - Run bit 1 lets channel 1 counter advance; zero halts it.
// - Run bit 0 lets channel 0 counter advance; zero halts it.
// - Reserved bits of all three registers read one and ignore writes.
// - Mode bit 7 pairs channel 1 registers B and D as buffer.
// - Mode bit 6 enables buffering of channel 1 register C with A.
// - Mode bit 5 pairs channel 0 registers B and D as buffer.
// - Mode bit 4 pairs channel 0 registers A and C as buffer.
// - Mode bit 0 locks both counters for joint preset and clear.
// - Pwm bits 6,5,4 put channel 1 D, C, B pins in pwm.
// - Pwm bits 2,1,0 put channel 0 D, C, B pins in pwm.
// - Each pin is compare output or capture input; channel 0 A takes clock.
// - Channel 0 C pin gives pwm sync output in combined modes.
// - Channel 1 A pin gives pwm output in combined modes.
// - Combined mode overrides pin pwm bits (the code forces only the two sync pins; the other pwm bits still apply); counters stopped before selecting it.
//
// Register access over APB and the register addresses are this design's own decisions.
module dtcc_common_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] capture_sel,
	input wire logic ext_clock_enable,
	output logic run_ch0,
	output logic run_ch1,
	output logic lockstep,
	output logic buffer_pair_c_ch0,
	output logic buffer_pair_d_ch0,
	output logic buffer_pair_c_ch1,
	output logic buffer_pair_d_ch1,
	output logic [1:0] combined_mode,
	output logic comb_rejected,
	output logic [15:0] pin_role
);
	import dtcc_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic access;
	logic wr_run;
	logic wr_mode;
	logic wr_pwm;
	logic wr_comb;
	logic mapped;
	logic [7:0] run_q;
	logic [7:0] mode_q;
	logic [7:0] pwm_q;
	logic [1:0] comb_q;
	logic comb_pwm;
	logic [7:0] pwm_eff;
	logic [7:0] role_clk;
	logic comb_block;

	assign access = psel && penable;
	assign mapped = (paddr == DTCC_RUN_ADDR) || (paddr == DTCC_MODE_ADDR) ||
		(paddr == DTCC_PWM_ADDR) || (paddr == DTCC_COMB_ADDR) || (paddr == DTCC_STAT_ADDR);
	assign wr_run = access && pwrite && (paddr == DTCC_RUN_ADDR);
	assign wr_mode = access && pwrite && (paddr == DTCC_MODE_ADDR);
	assign wr_pwm = access && pwrite && (paddr == DTCC_PWM_ADDR);
	assign wr_comb = access && pwrite && (paddr == DTCC_COMB_ADDR) && !comb_block;
	// Every register answers in its access cycle, so no wait state is inserted.
	assign pready = 1'b1;
	// An unmapped address reports an error, reads zero and changes nothing.
	assign pslverr = access && !mapped;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// reserved bits forced
	dtcc_reg8 #(.RSV(DTCC_RUN_RSV), .RESET(DTCC_RUN_RESET)) u_run (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_run),
		.wdata(pwdata[7:0]),
		.q(run_q)
	);
	dtcc_reg8 #(.RSV(DTCC_MODE_RSV), .RESET(DTCC_MODE_RESET)) u_mode (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_mode),
		.wdata(pwdata[7:0]),
		.q(mode_q)
	);
	dtcc_reg8 #(.RSV(DTCC_PWM_RSV), .RESET(DTCC_PWM_RESET)) u_pwm (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr_pwm),
		.wdata(pwdata[7:0]),
		.q(pwm_q)
	);

	// A combined mode may only be entered while both counters stand still;
	// refusing the write protects the phase relation of the two channels.
	logic [1:0] comb_wdata;
	assign comb_wdata = pwdata[1:0];
	assign comb_block = (comb_wdata != DTCC_COMB_NORMAL) &&
		(run_q[DTCC_RUN_CH0] || run_q[DTCC_RUN_CH1]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comb_q <= DTCC_COMB_NORMAL;
		end else if (wr_comb) begin
			comb_q <= comb_wdata;
		end
	end

	// Sticky until the next write to the combined-mode register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comb_rejected <= 1'b0;
		end else if (access && pwrite && (paddr == DTCC_COMB_ADDR)) begin
			comb_rejected <= comb_block;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Data is captured at the setup edge so that it already stands when the master
	// samples it in the access phase; it holds until the next read setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				DTCC_RUN_ADDR: prdata <= {24'h000000, run_q};
				DTCC_MODE_ADDR: prdata <= {24'h000000, mode_q};
				DTCC_PWM_ADDR: prdata <= {24'h000000, pwm_q};
				DTCC_COMB_ADDR: prdata <= {30'h0, comb_q};
				DTCC_STAT_ADDR: prdata <= {31'h0, comb_rejected};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Controls to the channels
	// ----------------------------------------------------------------
	// channel 1 run
	assign run_ch1 = run_q[DTCC_RUN_CH1];
	assign run_ch0 = run_q[DTCC_RUN_CH0];
	assign lockstep = mode_q[DTCC_LOCKSTEP];
	assign buffer_pair_d_ch1 = mode_q[DTCC_BUF_D_CH1];
	assign buffer_pair_c_ch1 = mode_q[DTCC_BUF_C_CH1];
	assign buffer_pair_d_ch0 = mode_q[DTCC_BUF_D_CH0];
	assign buffer_pair_c_ch0 = mode_q[DTCC_BUF_C_CH0];
	assign combined_mode = comb_q;
	assign comb_pwm = (comb_q != DTCC_COMB_NORMAL);

	// Pin order in the vectors: 0..3 = A,B,C,D of channel 0; 4..7 = channel 1.
	// Pin A of each channel has no pwm bit, so its slot stays zero.
	always_comb begin
		pwm_eff = 8'h00;
		pwm_eff[1] = pwm_q[DTCC_PWM_B_CH0];
		pwm_eff[2] = pwm_q[DTCC_PWM_C_CH0];
		pwm_eff[3] = pwm_q[DTCC_PWM_D_CH0];
		pwm_eff[5] = pwm_q[DTCC_PWM_B_CH1];
		pwm_eff[6] = pwm_q[DTCC_PWM_C_CH1];
		pwm_eff[7] = pwm_q[DTCC_PWM_D_CH1];
	end

	// Only channel 0 A can take the count clock; the other slots stay zero.
	// external clock on channel 0 A
	assign role_clk = {7'h00, ext_clock_enable};

	// The combined modes force only the sync pins; the per-pin bits of B, D and channel 1 C
	// still apply, so software clears them if those pins are wanted elsewhere.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			dtcc_pin_role u_role (
				.capture_sel(capture_sel[gi]),
				.pwm_sel(pwm_eff[gi]),
				.comb_pwm(comb_pwm && (gi == 2 || gi == 4)),
				.clock_sel(role_clk[gi]),
				.role(pin_role[2*gi+1:2*gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence run_write_s;
		wr_run;
	endsequence

	run_ch1_follow_a: assert property (run_write_s |=> run_ch1 == $past(pwdata[1]))
		else $error("channel 1 run bit did not follow write");
	run_ch0_follow_a: assert property (run_write_s |=> run_ch0 == $past(pwdata[0]))
		else $error("channel 0 run bit did not follow write");
	reserved_ones_a: assert property ((run_q[7:2] == 6'h3F) && (mode_q[3:1] == 3'h7) &&
		pwm_q[7] && pwm_q[3])
		else $error("reserved bit read zero");
	buf_d1_follow_a: assert property (wr_mode |=> buffer_pair_d_ch1 == $past(pwdata[7]))
		else $error("channel 1 D buffer pairing wrong");
	buf_c1_follow_a: assert property (wr_mode |=> buffer_pair_c_ch1 == $past(pwdata[6]))
		else $error("channel 1 C buffer pairing wrong");
	buf_d0_follow_a: assert property (wr_mode |=> buffer_pair_d_ch0 == $past(pwdata[5]))
		else $error("channel 0 D buffer pairing wrong");
	buf_c0_follow_a: assert property (wr_mode |=> buffer_pair_c_ch0 == $past(pwdata[4]))
		else $error("channel 0 C buffer pairing wrong");
	lockstep_follow_a: assert property (wr_mode |=> lockstep == $past(pwdata[0]))
		else $error("lockstep bit wrong");
	pwm_ch1_pin_a: assert property (!comb_pwm && pwm_q[6] |-> pin_role[15:14] == 2'b10)
		else $error("channel 1 D pin not in pwm");
	pwm_ch0_pin_a: assert property (pwm_q[1] |-> pin_role[5:4] == 2'b10)
		else $error("channel 0 C pin not in pwm");
	ext_clock_pin_a: assert property (ext_clock_enable && !pwm_eff[0] |->
		pin_role[1:0] == 2'b11)
		else $error("channel 0 A pin not clock input");
	sync_out_pin_a: assert property (comb_pwm |-> pin_role[5:4] == 2'b10)
		else $error("channel 0 C pin lacks sync output");
	ch1_a_pwm_a: assert property (comb_pwm |-> pin_role[9:8] == 2'b10)
		else $error("channel 1 A pin lacks pwm output");
	comb_guard_a: assert property (comb_block && access && pwrite &&
		paddr == DTCC_COMB_ADDR |=> $stable(comb_q) && comb_rejected)
		else $error("combined mode entered with counters running");

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	// Read data is taken at the setup edge, so each read sequence marks that
	// edge and the check looks one cycle later, while the access phase stands.
	sequence run_read_s;
		psel && !penable && !pwrite && (paddr == DTCC_RUN_ADDR);
	endsequence
	sequence mode_read_s;
		psel && !penable && !pwrite && (paddr == DTCC_MODE_ADDR);
	endsequence
	sequence pwm_read_s;
		psel && !penable && !pwrite && (paddr == DTCC_PWM_ADDR);
	endsequence
	sequence comb_read_s;
		psel && !penable && !pwrite && (paddr == DTCC_COMB_ADDR);
	endsequence
	sequence stat_read_s;
		psel && !penable && !pwrite && (paddr == DTCC_STAT_ADDR);
	endsequence

	run_read_a: assert property (run_read_s |=> prdata == {24'h000000, $past(run_q)})
		else $error("run register read back wrong");
	run_rsv_read_a: assert property (run_read_s |=> prdata[7:2] == 6'h3F)
		else $error("run register reserved bits read zero");
	mode_read_a: assert property (mode_read_s |=> prdata == {24'h000000, $past(mode_q)})
		else $error("mode register read back wrong");
	pwm_read_a: assert property (pwm_read_s |=> prdata == {24'h000000, $past(pwm_q)})
		else $error("pin pwm register read back wrong");
	comb_read_a: assert property (comb_read_s |=> prdata == {30'h0, $past(comb_q)})
		else $error("combined mode read back wrong");
	stat_read_a: assert property (stat_read_s |=>
		prdata == {31'h0, $past(comb_rejected)})
		else $error("refusal flag read back wrong");

	// ----------------------------------------------------------------
	// Register hold and combined-mode update
	// ----------------------------------------------------------------
	// A register may change only at its own write strobe; any other change would
	// start a counter or move a pin without software asking for it.
	sequence comb_write_s;
		access && pwrite && (paddr == DTCC_COMB_ADDR);
	endsequence

	run_hold_a: assert property (!wr_run |=> $stable(run_q))
		else $error("run register changed without a write");
	mode_hold_a: assert property (!wr_mode |=> $stable(mode_q))
		else $error("mode register changed without a write");
	pwm_hold_a: assert property (!wr_pwm |=> $stable(pwm_q))
		else $error("pin pwm register changed without a write");
	comb_hold_a: assert property (!wr_comb |=> $stable(comb_q))
		else $error("combined mode changed without an accepted write");
	comb_accept_a: assert property (wr_comb |=>
		(comb_q == $past(pwdata[1:0])) && !comb_rejected)
		else $error("accepted combined mode not taken");
	comb_flag_a: assert property (comb_write_s |=> comb_rejected == $past(comb_block))
		else $error("refusal flag does not match the last write");
	rsv_run_write_a: assert property (wr_run |=> run_q[7:2] == 6'h3F)
		else $error("run register reserved bits took a write");
	rsv_mode_write_a: assert property (wr_mode |=> mode_q[3:1] == 3'h7)
		else $error("mode register reserved bits took a write");
	rsv_pwm_write_a: assert property (wr_pwm |=> pwm_q[7] && pwm_q[3])
		else $error("pin pwm register reserved bits took a write");

	// ----------------------------------------------------------------
	// Pin roles
	// ----------------------------------------------------------------
	// Channel 0 A has no pwm bit of its own; its only extra role is the count clock.
	// A pwm bit wins over capture, so each capture check excludes it.
	pwm_c1_pin_a: assert property (pwm_q[5] |-> pin_role[13:12] == 2'b10)
		else $error("channel 1 C pin not in pwm");
	pwm_b1_pin_a: assert property (pwm_q[4] |-> pin_role[11:10] == 2'b10)
		else $error("channel 1 B pin not in pwm");
	pwm_d0_pin_a: assert property (pwm_q[2] |-> pin_role[7:6] == 2'b10)
		else $error("channel 0 D pin not in pwm");
	pwm_b0_pin_a: assert property (pwm_q[0] |-> pin_role[3:2] == 2'b10)
		else $error("channel 0 B pin not in pwm");
	a0_no_pwm_a: assert property (pin_role[1:0] != 2'b10)
		else $error("channel 0 A pin took a pwm role");
	clock_over_cap_a: assert property (ext_clock_enable && capture_sel[0] |->
		pin_role[1:0] == 2'b11)
		else $error("channel 0 A pin capture beat the count clock");
	capture_a0_a: assert property (capture_sel[0] && !ext_clock_enable |->
		pin_role[1:0] == 2'b01)
		else $error("channel 0 A pin not a capture input");
	capture_b0_a: assert property (capture_sel[1] && !pwm_q[0] |->
		pin_role[3:2] == 2'b01)
		else $error("channel 0 B pin not a capture input");
	compare_b0_a: assert property (!capture_sel[1] && !pwm_q[0] |->
		pin_role[3:2] == 2'b00)
		else $error("channel 0 B pin not a compare output");
	capture_c0_a: assert property (capture_sel[2] && !pwm_q[1] && !comb_pwm |->
		pin_role[5:4] == 2'b01)
		else $error("channel 0 C pin not a capture input");
	capture_c1_a: assert property (capture_sel[6] && !pwm_q[5] |->
		pin_role[13:12] == 2'b01)
		else $error("channel 1 C pin not a capture input");
	compare_c1_a: assert property (!capture_sel[6] && !pwm_q[5] |->
		pin_role[13:12] == 2'b00)
		else $error("channel 1 C pin not a compare output");
	capture_d1_a: assert property (capture_sel[7] && !pwm_q[6] |->
		pin_role[15:14] == 2'b01)
		else $error("channel 1 D pin not a capture input");
	capture_a1_a: assert property (capture_sel[4] && !comb_pwm |->
		pin_role[9:8] == 2'b01)
		else $error("channel 1 A pin not a capture input");
	compare_a1_a: assert property (!capture_sel[4] && !comb_pwm |->
		pin_role[9:8] == 2'b00)
		else $error("channel 1 A pin not a compare output");
	comb_c0_over_a: assert property (comb_pwm && capture_sel[2] |->
		pin_role[5:4] == 2'b10)
		else $error("combined mode lost channel 0 C pin to capture");
	comb_a1_over_a: assert property (comb_pwm && capture_sel[4] |->
		pin_role[9:8] == 2'b10)
		else $error("combined mode lost channel 1 A pin to capture");
endmodule

//--- dtcc_pin_side.sv
// Far-side model of the capture/compare pins and the external clock pin.
module dtcc_pin_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] want_capture,
	input wire logic want_clock,
	output logic [7:0] capture_sel,
	output logic ext_clock_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	// capture and clock pins
	// Levels move just after an edge, as a synchronous circuit outside would drive them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_sel <= 8'h00;
			ext_clock_enable <= 1'b0;
		end else begin
			capture_sel <= want_capture;
			ext_clock_enable <= want_clock;
		end
	end
endmodule

//--- dtcc_common_ctrl_tb.sv
// Self-checking testbench of the dual timer common control.
module dtcc_common_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dtcc_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, want_cap = 8'h00, capture_sel, pwm_now = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, se, want_clk = 1'b0, ext_clock_enable;
	logic run_ch0, run_ch1, lockstep, bc0, bd0, bc1, bd1, comb_rejected;
	logic [1:0] combined_mode, cm_now = 2'b00;
	logic [15:0] pin_role;
	int err_count = 0;
	int checked = 0;
	always #50 pclk = ~pclk;
	dtcc_pin_side u_dtcc_pin_side (.pclk(pclk), .presetn(presetn), .want_capture(want_cap),
		.want_clock(want_clk), .capture_sel(capture_sel), .ext_clock_enable(ext_clock_enable));
	dtcc_common_ctrl u_dtcc_common_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_sel(capture_sel),
		.ext_clock_enable(ext_clock_enable), .run_ch0(run_ch0), .run_ch1(run_ch1),
		.lockstep(lockstep), .buffer_pair_c_ch0(bc0), .buffer_pair_d_ch0(bd0),
		.buffer_pair_c_ch1(bc1), .buffer_pair_d_ch1(bd1), .combined_mode(combined_mode),
		.comb_rejected(comb_rejected), .pin_role(pin_role));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One edge with psel low separates transfers, so no signal is assigned twice at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			end_sim();
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
		@(negedge pclk);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
		check("read error", 32'(se), 32'h0); // mapped register answers
	endtask
	function automatic logic [15:0] role_exp(logic [7:0] cap, logic ext, logic [7:0] pwm,
		logic [1:0] cm);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (cap[i]) r[2*i +: 2] = 2'b01;
			if (i == 0 && ext) r[1:0] = 2'b11;
			if (i != 0 && i != 4 && pwm[i-1]) r[2*i +: 2] = 2'b10;
			if ((i == 2 || i == 4) && cm != 2'b00) r[2*i +: 2] = 2'b10;
		end
		return r;
	endfunction
	task automatic roles(input logic [7:0] cap, input logic ext);
		logic [15:0] exp_role;
		exp_role = role_exp(cap, ext, pwm_now, cm_now);
		want_cap <= cap;
		want_clk <= ext;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("pin roles", 32'(pin_role), 32'(exp_role));
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdchk("run reset", DTCC_RUN_ADDR, 32'h000000FC); // reserved reads one
		rdchk("mode reset", DTCC_MODE_ADDR, 32'h0000000E); // reserved reads one
		rdchk("pwm reset", DTCC_PWM_ADDR, 32'h00000088); // reserved reads one
		check("reset outs", 32'({run_ch1, run_ch0, bd1, bc1, bd0, bc0, lockstep}), 32'h0);
	endtask
	task automatic t_run();
		for (int v = 3; v >= 0; v--) begin
			wr(DTCC_RUN_ADDR, 8'(v));
			check("run ch0", 32'(run_ch0), 32'(v & 1)); // channel 0 start
			check("run ch1", 32'(run_ch1), 32'(v >> 1)); // channel 1 start
			rdchk("run read", DTCC_RUN_ADDR, 32'h000000FC | 32'(v)); // run bits taken, reserved bits read one
		end
	endtask
	task automatic t_mode();
		logic [7:0] m;
		for (int i = 0; i < 6; i++) begin
			m = (i == 5) ? 8'h00 : ((i == 4) ? 8'h01 : (8'h80 >> i));
			wr(DTCC_MODE_ADDR, m);
			check("mode bufs", 32'({bd1, bc1, bd0, bc0}), 32'(m[7:4]));
			check("lockstep", 32'(lockstep), 32'(m[0])); // counter lockstep
			rdchk("mode read", DTCC_MODE_ADDR, {24'h0, m | 8'h0E}); // reserved bits
		end
	endtask
	task automatic t_pwm();
		for (int b = 0; b < 8; b++) begin
			pwm_now = (b == 7) ? 8'h00 : (8'h01 << b);
			wr(DTCC_PWM_ADDR, pwm_now | 8'h88);
			pwm_now = pwm_now & 8'h77;
			rdchk("pwm read", DTCC_PWM_ADDR, {24'h0, pwm_now | 8'h88}); // reserved bits
			roles(8'h00, 1'b0);
		end
		roles(8'hFF, 1'b1);
		roles(8'hA5, 1'b0);
	endtask
	task automatic t_comb();
		for (int c = 1; c < 4; c++) begin
			cm_now = 2'(c);
			wr(DTCC_COMB_ADDR, 8'(c));
			check("comb mode", 32'(combined_mode), 32'(c)); // accepted while stopped
			rdchk("comb read", DTCC_COMB_ADDR, 32'(c)); // mode reads back
			roles(8'hFF, 1'b1);
			pwm_now = 8'h77;
			wr(DTCC_PWM_ADDR, pwm_now);
			roles(8'h5A, 1'b0);
			pwm_now = 8'h00;
			wr(DTCC_PWM_ADDR, pwm_now);
		end
		cm_now = 2'b00;
		wr(DTCC_COMB_ADDR, 8'h00);
		wr(DTCC_RUN_ADDR, 8'h02);
		wr(DTCC_COMB_ADDR, 8'h01);
		check("comb refused", 32'({comb_rejected, combined_mode}), 32'h4); // refused
		rdchk("status", DTCC_STAT_ADDR, 32'h1); // refusal visible
		rdchk("comb kept", DTCC_COMB_ADDR, 32'h0); // mode not taken
		roles(8'h00, 1'b0);
		wr(DTCC_RUN_ADDR, 8'h00);
	endtask
	task automatic t_unmapped();
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped read", rd, 32'h0); // no register there
		check("unmapped read error", 32'(se), 32'h1); // no register there
		apb(1'b1, 8'h14, 32'h3);
		check("unmapped write", 32'(se), 32'h1); // no register there
		rdchk("run kept", DTCC_RUN_ADDR, 32'h000000FC); // no side effect
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_run();
		t_mode();
		t_pwm();
		t_comb();
		t_unmapped();
		end_sim();
	end
endmodule
